// *** hdl/bridge_seq_pkg.sv ***
/*
 Constants, timing counts and carrier types for the phase-shift bridge sequencer.
 Assumes a single 200 MHz system clock; levels are unsigned codes of 5 mV per step.
*/
package bridge_seq_pkg;

	// Clock and oscillator
	localparam int CLK_MHZ = 200;
	localparam int OSC_FREQ_KHZ = 400;
	localparam int OSC_CYC = (CLK_MHZ * 1000) / OSC_FREQ_KHZ;
	localparam int POS_W = 12;

	// Fixed internal dead-time and rectifier turn-on gap, least times round up
	localparam int FIXED_DEAD_NS = 30;
	localparam int FIXED_DEAD_CYC = (FIXED_DEAD_NS * CLK_MHZ + 999) / 1000;
	localparam int RECT_ON_GAP_NS = 30;
	localparam int RECT_ON_GAP_CYC = (RECT_ON_GAP_NS * CLK_MHZ + 999) / 1000;
	localparam int GAP_W = 4;

	// Programmed delays, in system clock cycles
	localparam int DLY_W = 8;
	localparam int LEAD_W = 9;
	localparam logic [LEAD_W-1:0] LEAD_RESET = 9'h1FF;

	// Level scaling for soft-start, loop error and ramp
	localparam int LVL_W = 10;
	localparam int LVL_LSB_MV = 5;
	localparam logic [LVL_W-1:0] LVL_MAX = 10'h3FF;
	localparam int SS_OFFSET_MV = 1000;
	localparam logic [LVL_W-1:0] SS_OFFSET_LVL = LVL_W'(SS_OFFSET_MV / LVL_LSB_MV);
	localparam int SS_STEP_CYC = 200;

	// Slope compensation full scale, in microamps
	localparam int SLOPE_MAX_UA = 100;
	localparam int SLOPE_W = 7;

	// Gate and rectifier commands
	typedef struct packed {
		logic high_a;
		logic high_b;
		logic low_a;
		logic low_b;
		logic rect_a;
		logic rect_b;
	} gate_cmd_t;

	// Interval within one oscillator period
	typedef enum logic [2:0] {
		ST_LEAD = 3'b001,
		ST_ACTIVE = 3'b010,
		ST_PASSIVE = 3'b100
	} seq_state_t;

endpackage

// *** hdl/input_sync.sv ***
/*
 Three-stage synchroniser for one pin input with agreement filter.
 Assumes the pin is a slow level; output changes once stages two and three agree.
*/
`timescale 1ns/10ps
module input_sync (
	// Clock and reset
	input wire logic sys_clk_in,
	input wire logic reset_in,
	// Pin and synchronised level
	input wire logic async_in,
	output logic level_out
);
	logic meta_reg;
	logic stage2_reg;
	logic stage3_reg;

	// Chain; the first stage feeds only the second
	always_ff @(posedge sys_clk_in) begin
		if (reset_in) begin
			meta_reg <= 1'b0;
			stage2_reg <= 1'b0;
			stage3_reg <= 1'b0;
		end else begin
			meta_reg <= async_in;
			stage2_reg <= meta_reg;
			stage3_reg <= stage2_reg;
		end
	end

	// Accept a change only when the last two stages agree
	always_ff @(posedge sys_clk_in) begin
		if (reset_in) begin
			level_out <= 1'b0;
		end else if (stage2_reg == stage3_reg) begin
			level_out <= stage3_reg;
		end
	end
endmodule

// *** hdl/phase_shift_bridge_sequencer.sv ***
/*
 Phase-shifted full-bridge sequencer: four bridge gate commands, two rectifier commands,
 soft-start level, duty comparison and slope compensation code.
 Assumes comparator levels and delay settings arrive on the system clock; ready and
 soft-start hold inputs are pins and are synchronised here.
*/
`timescale 1ns/10ps
module phase_shift_bridge_sequencer #(
	parameter int OSC_CYC = bridge_seq_pkg::OSC_CYC,
	parameter int SS_STEP_CYC = bridge_seq_pkg::SS_STEP_CYC
) (
	// Clock and reset
	input wire logic sys_clk_in,
	input wire logic reset_in,
	// Monitor pins and soft-start hold pin
	input wire logic uvlo_ready_in,
	input wire logic vcc_ready_in,
	input wire logic ref_ready_in,
	input wire logic ss_force_zero_in,
	// Comparator levels
	input wire logic [bridge_seq_pkg::LVL_W-1:0] comp_current_in,
	input wire logic [bridge_seq_pkg::LVL_W-1:0] modulation_ramp_in,
	// Delay settings in clock cycles
	input wire logic [bridge_seq_pkg::DLY_W-1:0] lead_delay_setting_in,
	input wire logic [bridge_seq_pkg::DLY_W-1:0] trail_delay_setting_in,
	// Commands and levels out
	output bridge_seq_pkg::gate_cmd_t gates_out,
	output logic [bridge_seq_pkg::SLOPE_W-1:0] slope_level_out,
	output logic [bridge_seq_pkg::LVL_W-1:0] softstart_level_out
);
	localparam int LW = bridge_seq_pkg::LVL_W;
	localparam int PW = bridge_seq_pkg::POS_W;

	logic [3:0] pin_raw, pin_sync;
	logic monitors_ready, ss_force, boundary, phase_reg, ss_tick, pulse_end;
	logic lead_done, ap_done, gap_done, exit_pulse, idle_rect;
	logic [PW-1:0] pos_cnt_reg, lead_seen_reg;
	logic [15:0] ss_div_reg;
	logic [LW-1:0] ss_level_reg, ss_eff, err_lvl, duty_ref;
	bridge_seq_pkg::seq_state_t state_reg;
	logic [bridge_seq_pkg::LEAD_W-1:0] lead_cnt_reg, lead_total;
	logic [bridge_seq_pkg::DLY_W-1:0] ap_cnt_reg;
	logic [bridge_seq_pkg::GAP_W-1:0] gap_cnt_reg;
	bridge_seq_pkg::gate_cmd_t gate_next;
	// Saturating subtraction for offsets and error inversion
	function automatic logic [LW-1:0] sat_sub(input logic [LW-1:0] a, input logic [LW-1:0] b);
		return (a > b) ? LW'(a - b) : '0;
	endfunction
	// Pin synchronisers
	assign pin_raw = {ss_force_zero_in, ref_ready_in, vcc_ready_in, uvlo_ready_in};
	generate
		for (genvar gi = 0; gi < 4; gi++) begin : g_sync
			input_sync u_sync (
				.sys_clk_in(sys_clk_in),
				.reset_in(reset_in),
				.async_in(pin_raw[gi]),
				.level_out(pin_sync[gi])
			);
		end
	endgenerate
	assign monitors_ready = &pin_sync[2:0];
	assign ss_force = pin_sync[3];
	// Oscillator position; any monitor drop hard-stops and restarts the period
	assign boundary = (pos_cnt_reg == PW'(OSC_CYC - 1));
	always_ff @(posedge sys_clk_in) begin
		if (reset_in || !monitors_ready) begin
			pos_cnt_reg <= '0;
		end else if (boundary) begin
			pos_cnt_reg <= '0;
		end else begin
			pos_cnt_reg <= pos_cnt_reg + 1'b1;
		end
	end
	// Phase alternates on every oscillator period
	always_ff @(posedge sys_clk_in) begin
		if (reset_in || !monitors_ready) begin
			phase_reg <= 1'b0;
		end else if (boundary) begin
			phase_reg <= ~phase_reg;
		end
	end
	// Soft-start step divider
	assign ss_tick = (ss_div_reg == 16'(SS_STEP_CYC - 1));
	always_ff @(posedge sys_clk_in) begin
		if (reset_in || ss_tick) begin
			ss_div_reg <= '0;
		end else begin
			ss_div_reg <= ss_div_reg + 1'b1;
		end
	end
	// Soft-start level: held at zero until ready and while forced low
	always_ff @(posedge sys_clk_in) begin
		if (reset_in || !monitors_ready || ss_force) begin
			ss_level_reg <= '0;
		end else if (ss_tick && ss_level_reg != bridge_seq_pkg::LVL_MAX) begin
			ss_level_reg <= ss_level_reg + 1'b1;
		end
	end
	// Duty reference; a zero reference ends the pulse even while the ramp sits at zero
	assign ss_eff = sat_sub(ss_level_reg, bridge_seq_pkg::SS_OFFSET_LVL);
	assign err_lvl = sat_sub(bridge_seq_pkg::LVL_MAX, comp_current_in);
	assign duty_ref = (ss_eff < err_lvl) ? ss_eff : err_lvl;
	assign pulse_end = (modulation_ramp_in > duty_ref) || (duty_ref == '0);
	// Lead dead-time: fixed part plus programmed part, counted from the clock edge
	assign lead_total = bridge_seq_pkg::LEAD_W'(bridge_seq_pkg::FIXED_DEAD_CYC)
		+ {1'b0, lead_delay_setting_in};
	assign lead_done = (lead_cnt_reg == '0);
	always_ff @(posedge sys_clk_in) begin
		if (reset_in || !monitors_ready) begin
			lead_cnt_reg <= bridge_seq_pkg::LEAD_RESET; // First period stays idle
			lead_seen_reg <= PW'(bridge_seq_pkg::LEAD_RESET);
		end else if (boundary) begin
			lead_cnt_reg <= lead_total;
			lead_seen_reg <= PW'(lead_total); // Setting may move mid-period
		end else if (!lead_done) begin
			lead_cnt_reg <= lead_cnt_reg - 1'b1;
		end
	end
	// End of transfer, including a skipped pulse at zero duty
	assign exit_pulse = (state_reg == bridge_seq_pkg::ST_ACTIVE && (boundary || pulse_end))
		|| (state_reg == bridge_seq_pkg::ST_LEAD && !boundary && lead_done && duty_ref == '0);
	// Trail delay and rectifier gap, both restarted at the end of transfer
	assign ap_done = (ap_cnt_reg == '0);
	assign gap_done = (gap_cnt_reg == '0);
	always_ff @(posedge sys_clk_in) begin
		if (reset_in || !monitors_ready) begin
			ap_cnt_reg <= '0;
		end else if (exit_pulse) begin
			ap_cnt_reg <= trail_delay_setting_in;
		end else if (!ap_done) begin
			ap_cnt_reg <= ap_cnt_reg - 1'b1;
		end
	end
	always_ff @(posedge sys_clk_in) begin
		if (reset_in || !monitors_ready) begin
			gap_cnt_reg <= '0;
		end else if (exit_pulse) begin
			gap_cnt_reg <= bridge_seq_pkg::GAP_W'(bridge_seq_pkg::RECT_ON_GAP_CYC);
		end else if (!gap_done) begin
			gap_cnt_reg <= gap_cnt_reg - 1'b1;
		end
	end
	// Interval sequence; transfer waits for the leg partner to be settled
	always_ff @(posedge sys_clk_in) begin
		if (reset_in || !monitors_ready) begin
			state_reg <= bridge_seq_pkg::ST_LEAD;
		end else begin
			case (state_reg)
				bridge_seq_pkg::ST_LEAD: begin
					if (boundary) begin
						state_reg <= bridge_seq_pkg::ST_LEAD;
					end else if (lead_done && duty_ref == '0) begin
						state_reg <= bridge_seq_pkg::ST_PASSIVE;
					end else if (lead_done && ap_done) begin
						state_reg <= bridge_seq_pkg::ST_ACTIVE;
					end
				end
				bridge_seq_pkg::ST_ACTIVE: begin
					if (boundary) begin
						state_reg <= bridge_seq_pkg::ST_LEAD;
					end else if (pulse_end) begin
						state_reg <= bridge_seq_pkg::ST_PASSIVE;
					end
				end
				bridge_seq_pkg::ST_PASSIVE: begin
					if (boundary) begin
						state_reg <= bridge_seq_pkg::ST_LEAD;
					end
				end
				default: begin
					state_reg <= bridge_seq_pkg::ST_LEAD;
				end
			endcase
		end
	end

	// Gate decode; the clock edge drops the freewheel device of the ending phase
	always_comb begin
		gate_next = '0;
		if (monitors_ready) begin
			case (state_reg)
				bridge_seq_pkg::ST_LEAD: begin
					if (!phase_reg) begin
						gate_next.low_b = ap_done;
						gate_next.rect_a = 1'b1;
					end else begin
						gate_next.high_b = ap_done;
						gate_next.rect_b = 1'b1;
					end
				end
				bridge_seq_pkg::ST_ACTIVE: begin
					if (!phase_reg) begin
						gate_next.high_a = 1'b1;
						gate_next.low_b = 1'b1;
						gate_next.rect_a = 1'b1;
					end else begin
						gate_next.high_b = 1'b1;
						gate_next.low_a = 1'b1;
						gate_next.rect_b = 1'b1;
					end
				end
				bridge_seq_pkg::ST_PASSIVE: begin
					if (!phase_reg) begin
						gate_next.high_a = 1'b1;
						gate_next.high_b = ap_done;
						gate_next.rect_a = 1'b1;
						gate_next.rect_b = gap_done;
					end else begin
						gate_next.low_a = 1'b1;
						gate_next.low_b = ap_done;
						gate_next.rect_b = 1'b1;
						gate_next.rect_a = gap_done;
					end
				end
				default: begin
					gate_next = '0;
				end
			endcase
		end
	end
	assign idle_rect = phase_reg ? gate_next.rect_a : gate_next.rect_b;

	// Registered outputs keep gate edges aligned to one clock
	always_ff @(posedge sys_clk_in) begin
		if (reset_in) begin
			gates_out <= '0;
			softstart_level_out <= '0;
		end else begin
			gates_out <= gate_next;
			softstart_level_out <= ss_level_reg;
		end
	end

	// Slope code, one cycle behind position: full scale in the first cycle of a period, zero in the second; constant divisor
	always_ff @(posedge sys_clk_in) begin
		if (reset_in) begin
			slope_level_out <= '0;
		end else begin
			slope_level_out <= bridge_seq_pkg::SLOPE_W'((32'(pos_cnt_reg)
				* bridge_seq_pkg::SLOPE_MAX_UA) / (OSC_CYC - 1));
		end
	end

	// Checks
	default clocking cb @(posedge sys_clk_in); endclocking
	// Hard stop on a monitor drop clears outputs out of sequence
	default disable iff (reset_in || !monitors_ready);
	diag_a_a: assert property (state_reg == bridge_seq_pkg::ST_ACTIVE && !phase_reg |=>
		gates_out.high_a && gates_out.low_b && !gates_out.high_b && !gates_out.low_a
		&& gates_out.rect_a && !gates_out.rect_b) else $error("phase A transfer wrong");
	diag_b_a: assert property (state_reg == bridge_seq_pkg::ST_ACTIVE && phase_reg |=>
		gates_out.high_b && gates_out.low_a && !gates_out.high_a && !gates_out.low_b
		&& gates_out.rect_b && !gates_out.rect_a) else $error("phase B transfer wrong");
	free_both_a: assert property (state_reg == bridge_seq_pkg::ST_PASSIVE && ap_done
		&& gap_done && monitors_ready |-> gate_next.rect_a && gate_next.rect_b
		&& (phase_reg ? (gate_next.low_a && gate_next.low_b)
		: (gate_next.high_a && gate_next.high_b))) else $error("freewheel set wrong");
	duty_ceiling_a: assert property (state_reg == bridge_seq_pkg::ST_ACTIVE |->
		pos_cnt_reg > lead_seen_reg) else $error("transfer began inside lead time");
	rect_gap_a: assert property ((state_reg == bridge_seq_pkg::ST_ACTIVE
		##1 state_reg == bridge_seq_pkg::ST_PASSIVE) |->
		(state_reg != bridge_seq_pkg::ST_PASSIVE || !idle_rect)[*6]
		##1 (state_reg != bridge_seq_pkg::ST_PASSIVE || idle_rect))
		else $error("idle rectifier gap wrong");
	rect_release_a: assert property ($fell(gates_out.high_a) && $past(monitors_ready, 2)
		|-> $fell(gates_out.rect_a)) else $error("rect_a not released with high_a");
	pulse_stop_a: assert property (state_reg == bridge_seq_pkg::ST_ACTIVE && pulse_end
		|=> state_reg != bridge_seq_pkg::ST_ACTIVE) else $error("pulse did not end");
	ss_hold_a: assert property (ss_force |=> ss_level_reg == '0 ##1
		(!ss_force || state_reg != bridge_seq_pkg::ST_ACTIVE)) else $error("duty not killed");
	phase_alt_a: assert property (boundary && monitors_ready |=> phase_reg != $past(phase_reg)
		&& state_reg == bridge_seq_pkg::ST_LEAD) else $error("phase did not alternate");
	slope_wrap_a: assert property (boundary |=> slope_level_out == 7'h64 ##1
		(!monitors_ready || slope_level_out == 7'h00)) else $error("slope did not restart");
	leg_gap_a: assert property (state_reg == bridge_seq_pkg::ST_PASSIVE && !ap_done |->
		!gate_next.high_b && !gate_next.low_b) else $error("leg partner on too early");
	full_cycle_c: cover property (state_reg == bridge_seq_pkg::ST_ACTIVE
		##[1:600] state_reg == bridge_seq_pkg::ST_PASSIVE ##[1:600] boundary);
	max_duty_c: cover property (state_reg == bridge_seq_pkg::ST_ACTIVE && boundary);
	zero_skip_c: cover property (state_reg == bridge_seq_pkg::ST_LEAD && lead_done
		&& duty_ref == '0 && !boundary);
endmodule

// *** verification/bridge_load_model.sv ***
/*
 Far-side model: the four bridge transistors and the two rectifier isolators.
 Assumes gate commands arrive registered on the system clock.
*/
`timescale 1ns/10ps
module bridge_load_model (
	// Clock and reset
	input wire logic sys_clk_in,
	input wire logic reset_in,
	// Commands from the sequencer
	input wire bridge_seq_pkg::gate_cmd_t gates_in,
	// Sticky power stage fault
	output logic fault_out
);
	// Shoot-through or a shorted secondary at transfer would destroy parts
	always_ff @(posedge sys_clk_in) begin
		if (reset_in) begin
			fault_out <= 1'b0;
		end else if ((gates_in.high_a && gates_in.low_a) || (gates_in.high_b && gates_in.low_b)) begin
			fault_out <= 1'b1;
		end else if ((gates_in.high_a && gates_in.low_b && gates_in.rect_b) ||
			(gates_in.high_b && gates_in.low_a && gates_in.rect_a)) begin
			fault_out <= 1'b1;
		end
	end
endmodule

// *** verification/phase_shift_bridge_sequencer_tb_top.sv ***
/*
 Self-checking bench for the bridge sequencer with a short oscillator period.
 Assumes the far-side model in bridge_load_model and 1 code per soft-start cycle.
*/
`timescale 1ns/10ps
module phase_shift_bridge_sequencer_tb_top;
	localparam int OSC = 60;
	logic sys_clk = 1'b0;
	logic rst = 1'b1;
	logic rdy_u = 1'b0;
	logic rdy_v = 1'b0;
	logic rdy_r = 1'b0;
	logic ss_zero = 1'b0;
	logic [9:0] comp = 10'h000;
	logic [9:0] ramp = 10'h000;
	logic [7:0] lead = 8'h00;
	logic [7:0] trail = 8'h00;
	bridge_seq_pkg::gate_cmd_t gates;
	logic [6:0] slope;
	logic [9:0] ss;
	logic fault;
	int n_errors = 0;
	int cmp_count = 0;
	int cyc = 0;
	int g0;
	int g8;

	// 200 MHz clock
	always #2.5 sys_clk = ~sys_clk;

	phase_shift_bridge_sequencer #(.OSC_CYC(OSC), .SS_STEP_CYC(1)) dut_u (
		.sys_clk_in(sys_clk), .reset_in(rst), .uvlo_ready_in(rdy_u), .vcc_ready_in(rdy_v),
		.ref_ready_in(rdy_r), .ss_force_zero_in(ss_zero), .comp_current_in(comp),
		.modulation_ramp_in(ramp), .lead_delay_setting_in(lead),
		.trail_delay_setting_in(trail), .gates_out(gates), .slope_level_out(slope),
		.softstart_level_out(ss));

	bridge_load_model load_u (.sys_clk_in(sys_clk), .reset_in(rst), .gates_in(gates),
		.fault_out(fault));

	task automatic conclude();
		if (n_errors == 0 && cmp_count > 0) begin
			$display("Result: passed");
		end else begin
			$display("Result: failed");
		end
		$finish;
	endtask

	task automatic chk(input logic [15:0] act, input logic [15:0] exp);
		cmp_count++;
		if (act !== exp) begin
			n_errors++;
			$display("MISMATCH t=%0t got %h exp %h", $time, act, exp);
		end
	endtask

	// Settle past the edge so registered outputs have landed
	task automatic tick(input int n);
		repeat (n) @(posedge sys_clk);
		#1;
	endtask

	task automatic drv(input logic [7:0] l, input logic [7:0] t, input logic [9:0] c,
		input logic [9:0] r);
		@(posedge sys_clk);
		lead <= l;
		trail <= t;
		comp <= c;
		ramp <= r;
		#1;
	endtask

	function automatic logic diag(input logic b);
		return b ? (gates.high_b && gates.low_a) : (gates.high_a && gates.low_b);
	endfunction

	// Finds the next transfer on one diagonal; rectifier pattern checked throughout
	task automatic pulse(input logic b, output int len);
		int w;
		w = 0;
		len = 0;
		while (!diag(b) && w < 3 * OSC) begin
			tick(1);
			w++;
		end
		while (diag(b) && len < 2 * OSC) begin
			chk({14'h0, gates.rect_a, gates.rect_b}, b ? 16'h1 : 16'h2);
			tick(1);
			len++;
		end
	endtask

	task automatic t_ready();
		tick(20);
		chk({6'h0, ss}, 16'h0);
		@(posedge sys_clk);
		rdy_u <= 1'b1;
		rdy_v <= 1'b1;
		tick(20);
		chk({10'h0, gates}, 16'h0);
		chk({6'h0, ss}, 16'h0);
		@(posedge sys_clk);
		rdy_r <= 1'b1;
		tick(30);
		chk({15'h0, ss != 10'h0}, 16'h1);
		tick(300);
	endtask

	// Loop error open and ramp flat: transfer runs to the period boundary
	task automatic t_maxduty(input logic [7:0] l, input logic [7:0] t);
		int la;
		int lb;
		drv(l, t, 10'h000, 10'h000);
		tick(2 * OSC);
		pulse(1'b1, lb);
		pulse(1'b0, la);
		chk(la[15:0], 16'(OSC - 1 - bridge_seq_pkg::FIXED_DEAD_CYC - int'(l)));
		chk({14'h0, gates.high_a, gates.rect_a}, 16'h0);
		pulse(1'b1, lb);
		chk(lb[15:0], 16'(OSC - 1 - bridge_seq_pkg::FIXED_DEAD_CYC - int'(l)));
		chk({14'h0, gates.low_a, gates.rect_b}, 16'h0);
	endtask

	// Ramp above the loop error level cuts the pulse short, leaving long freewheel
	task automatic window(input logic b, output int gh, output int gr);
		gh = 0;
		gr = 0;
		repeat (20) begin
			if (!(b ? gates.low_b : gates.high_b)) gh++;
			if (!(b ? gates.rect_a : gates.rect_b)) gr++;
			tick(1);
		end
	endtask

	task automatic t_freewheel(input logic [7:0] t, output int gap);
		int l;
		int gr;
		drv(8'h00, t, 10'h270, 10'h1F4);
		tick(2 * OSC);
		pulse(1'b1, l);
		pulse(1'b0, l);
		chk({15'h0, l >= 1 && l <= 2}, 16'h1);
		window(1'b0, gap, gr);
		chk(gr[15:0], 16'(bridge_seq_pkg::RECT_ON_GAP_CYC));
		chk({10'h0, gates}, 16'h33);
		pulse(1'b1, l);
		window(1'b1, l, gr);
		chk(gr[15:0], 16'(bridge_seq_pkg::RECT_ON_GAP_CYC));
		chk({10'h0, gates}, 16'h0F);
	endtask

	task automatic t_slope();
		int n100;
		int over;
		int n0;
		n100 = 0;
		over = 0;
		n0 = 0;
		repeat (2 * OSC) begin
			if (slope === 7'h64) n100++;
			if (slope === 7'h00) n0++;
			if (slope > 7'h64) over++;
			tick(1);
		end
		chk(n100[15:0], 16'h2);
		chk(over[15:0], 16'h0);
		chk(n0[15:0], 16'h2);
	endtask

	task automatic t_force();
		int l;
		@(posedge sys_clk);
		ss_zero <= 1'b1;
		tick(12);
		chk({6'h0, ss}, 16'h0);
		pulse(1'b0, l);
		chk(l[15:0], 16'h0);
		@(posedge sys_clk);
		ss_zero <= 1'b0;
		tick(20);
		chk({15'h0, ss != 10'h0 && ss < 10'h40}, 16'h1);
		tick(300);
		pulse(1'b0, l);
		chk({15'h0, l > 0}, 16'h1);
	endtask

	// Hang guard, well above the few thousand cycles the run needs
	always @(posedge sys_clk) begin
		cyc++;
		if (cyc == 10000) begin
			n_errors++;
			conclude();
		end
	end

	initial begin
		tick(7);
		chk({10'h0, gates}, 16'h0);
		chk({6'h0, ss}, 16'h0);
		@(posedge sys_clk);
		rst <= 1'b0;
		t_ready();
		t_maxduty(8'h00, 8'h00);
		t_maxduty(8'h0A, 8'h00);
		t_maxduty(8'h00, 8'h05);
		t_freewheel(8'h00, g0);
		t_freewheel(8'h08, g8);
		chk(16'(g8 - g0), 16'h8);
		t_slope();
		t_force();
		@(posedge sys_clk);
		rdy_v <= 1'b0;
		tick(10);
		chk({10'h0, gates}, 16'h0);
		chk({15'h0, fault}, 16'h0);
		conclude();
	end
endmodule
